// *** hw/tpo_pkg.sv ***
// Package: register map, field positions and reset values of the pattern output unit
`default_nettype none
package tpo_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [27:0] CTRL_IDX    = 28'hFFFF6E5;
	localparam logic [27:0] LOW_IDX     = 28'hFFFF6E6;
	localparam logic [27:0] HIGH_IDX    = 28'hFFFF6E7;
	localparam logic [27:0] BITSEL_IDX  = 28'hFFFF6E8;
	localparam logic [31:0] CTRL_ADDR   = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [31:0] LOW_ADDR    = {2'h0, LOW_IDX, 2'h0};
	localparam logic [31:0] HIGH_ADDR   = {2'h0, HIGH_IDX, 2'h0};
	localparam logic [31:0] BITSEL_ADDR = {2'h0, BITSEL_IDX, 2'h0};

	// Widths
	localparam int OUT_W = 6;
	localparam int NIB_W = 4;
	localparam int HI_W  = 2;

	// Output control fields
	localparam int RUN_BIT   = 7;
	localparam int EDGE_BIT  = 6;
	localparam int MERGE_BIT = 5;
	localparam int REMAP_BIT = 4;

	// Reset values
	localparam logic [7:0]       CTRL_RST   = 8'h00;
	localparam logic [7:0]       BITSEL_RST = 8'h00;
	localparam logic [3:0]       BUF_RST    = 4'h0;
	localparam logic [OUT_W-1:0] LATCH_RST  = 6'h00;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : tpo_pkg
`default_nettype wire

// *** hw/tpo_out_stage.sv ***
// Output stage: per-bit gating of latched pattern by run enable and bit select
`default_nettype none
module tpo_out_stage
(
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Gating inputs
	input  wire logic                     run,
	input  wire logic [tpo_pkg::OUT_W-1:0] latch,
	input  wire logic [tpo_pkg::OUT_W-1:0] sel,
	// Pattern output
	output var  logic [tpo_pkg::OUT_W-1:0] pattern_q
);
	genvar i;
	generate
		for (i = 0; i < tpo_pkg::OUT_W; i++)
		begin : g_bit
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					pattern_q[i] <= 1'b0;
				else
					pattern_q[i] <= run & sel[i] & latch[i];
			end
		end
	endgenerate
endmodule : tpo_out_stage
`default_nettype wire

// *** hw/tpo_top.sv ***
// Triggered pattern output unit with AXI4-Lite register slave
//
// Notes on behaviour
// - Split mode: low address writes low nibble only, high address writes high only.
// - Merged mode: a byte written to either buffer address updates both halves.
// - Reading either buffer address returns high buffer above, low buffer below.
// - Bit select picks pattern or port use per output bit; resets to zero.
// - Run enable low forces all six pattern outputs to zero.
// - Run enable high: selected bits drive latch, unselected bits drive zero.
// - While running, latches load only on the selected trigger event.
// - Trigger map: 00 split B/A, 01 high on A only, 10 all on A, 11 none.
// - Edge select bit is stored and read back but changes nothing.
// - Buffer write while stopped goes straight into the matching latch.
// - Buffer write while running waits for the next selected trigger.
// - Buffers accept whole-byte accesses only; a write needs wstrb[0].
// - Output control bits 7:4 are read/write, bits 3:0 always read zero; resets to zero.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
module tpo_top
(
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address
	input  wire logic [31:0]               awaddr,
	input  wire logic [2:0]                awprot,
	input  wire logic                      awvalid,
	output var  logic                      awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output var  logic                      wready,
	// AXI4-Lite write response
	output var  logic [1:0]                bresp,
	output var  logic                      bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read address
	input  wire logic [31:0]               araddr,
	input  wire logic [2:0]                arprot,
	input  wire logic                      arvalid,
	output var  logic                      arready,
	// AXI4-Lite read data
	output var  logic [31:0]               rdata,
	output var  logic [1:0]                rresp,
	output var  logic                      rvalid,
	input  wire logic                      rready,
	// Timer trigger pulses
	input  wire logic                      timer_a_event,
	input  wire logic                      timer_b_event,
	// Pattern outputs, first bit at 0, last at 5
	output var  logic [tpo_pkg::OUT_W-1:0] preset_pattern_output
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]                   ctrl_q;
	logic [7:0]                   bitsel_q;
	logic [3:0]                   low_buf_q;
	logic [3:0]                   high_buf_q;
	logic [tpo_pkg::NIB_W-1:0]    low_latch_q;
	logic [tpo_pkg::HI_W-1:0]     high_latch_q;
	logic                         awready_q;
	logic                         wready_q;
	logic                         bvalid_q;
	logic [1:0]                   bresp_q;
	logic                         arready_q;
	logic                         rvalid_q;
	logic [31:0]                  rdata_q;
	logic [1:0]                   rresp_q;

	logic                         run;
	logic                         merged;
	logic                         remap;
	logic                         wr_fire;
	logic                         rd_fire;
	logic                         wr_low;
	logic                         wr_high;
	logic                         wr_buf;
	logic                         wr_ctrl;
	logic                         wr_bitsel;
	logic                         wr_map;
	logic                         rd_map;
	logic                         ld_low_d;
	logic                         ld_high_d;
	logic [3:0]                   low_buf_d;
	logic [3:0]                   high_buf_d;
	logic [7:0]                   rd_val;

	assign run    = ctrl_q[tpo_pkg::RUN_BIT];
	assign merged = ctrl_q[tpo_pkg::MERGE_BIT];
	assign remap  = ctrl_q[tpo_pkg::REMAP_BIT];

	////////////////////////////////////////////////////////////////////////
	// Write channel
	assign wr_fire   = awready_q & awvalid & wvalid;
	assign wr_low    = wr_fire & wstrb[0] & (awaddr == tpo_pkg::LOW_ADDR);
	assign wr_high   = wr_fire & wstrb[0] & (awaddr == tpo_pkg::HIGH_ADDR);
	assign wr_ctrl   = wr_fire & wstrb[0] & (awaddr == tpo_pkg::CTRL_ADDR);
	assign wr_bitsel = wr_fire & wstrb[0] & (awaddr == tpo_pkg::BITSEL_ADDR);
	assign wr_buf    = wr_low | wr_high;
	assign wr_map    = (awaddr == tpo_pkg::LOW_ADDR) | (awaddr == tpo_pkg::HIGH_ADDR) |
	                   (awaddr == tpo_pkg::CTRL_ADDR) | (awaddr == tpo_pkg::BITSEL_ADDR);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
		end
		else
		begin
			awready_q <= ~awready_q & ~bvalid_q & awvalid & wvalid;
			wready_q  <= ~wready_q & ~bvalid_q & awvalid & wvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= tpo_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_map ? tpo_pkg::RESP_OKAY : tpo_pkg::RESP_DECERR;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Control and bit select
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_q <= tpo_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= {wdata[7:4], 4'h0};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bitsel_q <= tpo_pkg::BITSEL_RST;
		else if (wr_bitsel)
			bitsel_q <= {2'h0, wdata[tpo_pkg::OUT_W-1:0]};
	end

	////////////////////////////////////////////////////////////////////////
	// Buffers
	always_comb
	begin
		low_buf_d  = low_buf_q;
		high_buf_d = high_buf_q;
		if (wr_low | (wr_high & merged))
			low_buf_d = wdata[3:0];
		if (wr_high | (wr_low & merged))
			high_buf_d = wdata[7:4];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			low_buf_q  <= tpo_pkg::BUF_RST;
			high_buf_q <= tpo_pkg::BUF_RST;
		end
		else
		begin
			low_buf_q  <= low_buf_d;
			high_buf_q <= high_buf_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latch loads
	always_comb
	begin
		ld_low_d  = 1'b0;
		ld_high_d = 1'b0;
		if (!run)
		begin
			ld_low_d  = wr_buf;
			ld_high_d = wr_buf;
		end
		else
		begin
			unique case ({merged, remap})
				2'b00:
				begin
					ld_high_d = timer_b_event;
					ld_low_d  = timer_a_event;
				end
				2'b01:
					ld_high_d = timer_a_event;
				2'b10:
				begin
					ld_high_d = timer_a_event;
					ld_low_d  = timer_a_event;
				end
				default:
				begin
					ld_high_d = 1'b0;
					ld_low_d  = 1'b0;
				end
			endcase
		end
	end

	// Stopped: latches follow the buffer value being written; running: current buffer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			low_latch_q  <= tpo_pkg::LATCH_RST[tpo_pkg::NIB_W-1:0];
			high_latch_q <= tpo_pkg::LATCH_RST[tpo_pkg::OUT_W-1:tpo_pkg::NIB_W];
		end
		else
		begin
			if (ld_low_d & (run | low_buf_d != low_buf_q | wr_low | merged))
				low_latch_q <= run ? low_buf_q : low_buf_d;
			if (ld_high_d & (run | wr_high | merged))
				high_latch_q <= run ? high_buf_q[tpo_pkg::HI_W-1:0] : high_buf_d[tpo_pkg::HI_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	assign rd_fire = arready_q & arvalid;
	assign rd_map  = (araddr == tpo_pkg::LOW_ADDR) | (araddr == tpo_pkg::HIGH_ADDR) |
	                 (araddr == tpo_pkg::CTRL_ADDR) | (araddr == tpo_pkg::BITSEL_ADDR);

	always_comb
	begin
		rd_val = 8'h00;
		if ((araddr == tpo_pkg::LOW_ADDR) | (araddr == tpo_pkg::HIGH_ADDR))
			rd_val = {high_buf_q, low_buf_q};
		else if (araddr == tpo_pkg::CTRL_ADDR)
			rd_val = ctrl_q;
		else if (araddr == tpo_pkg::BITSEL_ADDR)
			rd_val = bitsel_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			arready_q <= 1'b0;
		else
			arready_q <= ~arready_q & ~rvalid_q & arvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= tpo_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_val};
			rresp_q  <= rd_map ? tpo_pkg::RESP_OKAY : tpo_pkg::RESP_DECERR;
		end
		else if (rready)
			rvalid_q <= 1'b0;
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Output stage
	tpo_out_stage u_out
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (run),
		.latch     ({high_latch_q, low_latch_q}),
		.sel       (bitsel_q[tpo_pkg::OUT_W-1:0]),
		.pattern_q (preset_pattern_output)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	stop_zero_a :
	assert property (!run |=> preset_pattern_output == 6'h00)
		else $error("pattern outputs not zero while stopped");

	run_gate_a :
	assert property (run |=> preset_pattern_output ==
		($past({high_latch_q, low_latch_q}) & $past(bitsel_q[tpo_pkg::OUT_W-1:0])))
		else $error("pattern output does not follow latch and bit select");

	split_low_a :
	assert property (wr_high & !merged |=> low_buf_q == $past(low_buf_q) &&
		high_buf_q == $past(wdata[7:4]))
		else $error("split high write disturbed low buffer");

	merged_wr_a :
	assert property (wr_buf & merged |=> {high_buf_q, low_buf_q} == $past(wdata[7:0]))
		else $error("merged write did not update both halves");

	buf_read_a :
	assert property (rd_fire & ((araddr == tpo_pkg::LOW_ADDR) | (araddr == tpo_pkg::HIGH_ADDR))
		|=> rvalid && rdata[7:0] == {$past(high_buf_q), $past(low_buf_q)})
		else $error("buffer read data wrong");

	run_hold_a :
	assert property (run & !timer_a_event & !timer_b_event |=>
		$stable(low_latch_q) && $stable(high_latch_q))
		else $error("latch changed while running without trigger");

	remap_high_a :
	assert property (run & !merged & remap & timer_a_event |=>
		high_latch_q == $past(high_buf_q[tpo_pkg::HI_W-1:0]) && $stable(low_latch_q))
		else $error("remapped trigger load wrong");

	stop_load_a :
	assert property (!run & wr_low & !merged |=> low_latch_q == $past(wdata[3:0]))
		else $error("stopped write not passed to latch");

	ctrl_reset_a :
	assert property (disable iff (1'b0) $rose(aresetn) |-> ctrl_q == 8'h00 && bitsel_q == 8'h00)
		else $error("control not zero after reset");
endmodule : tpo_top
`default_nettype wire

// *** verif/tpo_motor_drv.sv ***
// Stepping motor driver model at the far side of the pattern outputs
`default_nettype none
module tpo_motor_drv
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Phase drive from the pattern unit
	input  wire logic [5:0] phases,
	// Count of phase changes seen
	output var  int         steps_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] last_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			last_q  <= 6'h00;
			steps_q <= 0;
		end
		else
		begin
			last_q <= phases;
			if (phases !== last_q)
				steps_q <= steps_q + 1;
		end
	end
endmodule : tpo_motor_drv
`default_nettype wire

// *** verif/triggered_pattern_output_test.sv ***
// Testbench of the triggered pattern output unit against a reference model
`default_nettype none
module triggered_pattern_output_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, wvalid, arvalid, ta, tb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, seed;
	logic [1:0]  bresp, rresp, lhi;
	logic [5:0]  pat, last_exp;
	logic [7:0]  ctl, sel, v;
	logic [3:0]  blo, bhi, llo;
	int          errors, check_count, steps, exp_steps;
	localparam logic [1:0] OK = tpo_pkg::RESP_OKAY;
	localparam logic [31:0] C = tpo_pkg::CTRL_ADDR;
	localparam logic [31:0] S = tpo_pkg::BITSEL_ADDR;

	tpo_top i_tpo_top
	(
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(1'b1), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(1'b1), .timer_a_event(ta), .timer_b_event(tb),
		.preset_pattern_output(pat)
	);
	tpo_motor_drv i_tpo_motor_drv
	(
		.aclk(aclk), .aresetn(aresetn), .phases(pat), .steps_q(steps)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
		check_count++;
		if (seen_v !== exp_v)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp_v, seen_v);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		chk("rdata", rdata, ed);
	endtask : rd

	task automatic cko();
		logic [5:0] e;
		@(posedge aclk);
		e = ctl[7] ? ({lhi, llo} & sel[5:0]) : 6'h00;
		chk("pattern", {26'h0, pat}, {26'h0, e});
		// Every pattern change is seen here once, so the driver's step count can be predicted
		if (e !== last_exp)
			exp_steps++;
		last_exp = e;
	endtask : cko

	task automatic wbuf(input logic hi, input logic [7:0] d);
		d = (hi || ctl[5]) ? d & 8'h3F : d;
		wr(hi ? tpo_pkg::HIGH_ADDR : tpo_pkg::LOW_ADDR, d, OK);
		if (ctl[5] || hi)
			bhi = d[7:4];
		if (ctl[5] || !hi)
			blo = d[3:0];
		if (!ctl[7] && (ctl[5] || hi))
			lhi = bhi[1:0];
		if (!ctl[7] && (ctl[5] || !hi))
			llo = blo;
		rd(tpo_pkg::LOW_ADDR, OK, {24'h0, bhi, blo});
		rd(tpo_pkg::HIGH_ADDR, OK, {24'h0, bhi, blo});
		cko();
	endtask : wbuf

	task automatic trig(input logic b);
		if (b)
			tb <= 1'b1;
		else
			ta <= 1'b1;
		@(posedge aclk);
		ta <= 1'b0;
		tb <= 1'b0;
		@(posedge aclk);
		if (ctl[7] && !b && !ctl[4])
			llo = blo;
		if (ctl[7] && (b ? ctl[5:4] == 2'b00 : ctl[5:4] == 2'b01 || ctl[5:4] == 2'b10))
			lhi = bhi[1:0];
		cko();
	endtask : trig

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	initial
	begin
		#60000;
		errors++;
		conclude();
	end

	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, ta, tb} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		seed = 32'h00008FB5;
		errors = 0;
		check_count = 0;
		exp_steps = 0;
		last_exp = 6'h00;
		{ctl, sel, blo, bhi, llo, lhi} = 30'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(C, OK, 32'h0);
		rd(S, OK, 32'h0);
		rd(tpo_pkg::LOW_ADDR, OK, 32'h0);
		wr(32'h0, 8'hFF, tpo_pkg::RESP_DECERR);
		rd(32'h0, tpo_pkg::RESP_DECERR, 32'h0);
		rd(C, OK, 32'h0);
		wr(S, 8'hFF, OK);
		sel = 8'h3F;
		rd(S, OK, 32'h3F);
		ctl = 8'h80;
		wr(C, ctl, OK);
		cko();
		$display("test reset and registers done");
		for (int m = 0; m < 4; m++)
		begin
			ctl = 8'h00;
			wr(C, ctl, OK);
			cko();
			v = rnd();
			ctl = {1'b0, v[0], m[1:0], 4'h0};
			wr(C, ctl, OK);
			rd(C, OK, {24'h0, ctl});
			sel = rnd() & 8'h3F;
			wr(S, sel, OK);
			trig(1'b0);
			trig(1'b1);
			wbuf(1'b0, rnd());
			wbuf(1'b1, rnd());
			ctl[7] = 1'b1;
			wr(C, ctl, OK);
			cko();
			repeat (4)
			begin
				v = rnd();
				wbuf(v[1], rnd());
				trig(v[0]);
				trig(v[2]);
			end
			$display("test mode %0d done", m);
		end
		repeat (2) @(posedge aclk);
		chk("steps", steps, exp_steps);
		conclude();
	end
endmodule : triggered_pattern_output_test
`default_nettype wire
